// ### inc/lsp_map.vh
// Register offsets, field positions, reset values and timing counts of the scan PWM block
`ifndef LSP_MAP_VH
`define LSP_MAP_VH
// Register pages
`define LSP_PG_BRIGHT      2'h0
`define LSP_PG_SCALE       2'h1
`define LSP_PG_FUNC        2'h2
// Function page offsets
`define LSP_OFF_CONFIG     8'h00
`define LSP_OFF_GCL        8'h01
`define LSP_OFF_PULL       8'h02
`define LSP_OFF_FAULT_LO   8'h03
`define LSP_OFF_FAULT_HI   8'h1A
// Array sizes
`define LSP_ROWS           8
`define LSP_COLS           18
`define LSP_LEDS           144
`define LSP_LED_LAST       8'h8F
`define LSP_FAULT_REGS     24
`define LSP_FAULT_BITS     6
// Configuration fields
`define LSP_CFG_RUN_BIT    0
`define LSP_CFG_DET_LSB    1
`define LSP_CFG_DET_MSB    2
// Detect trigger codes
`define LSP_DET_IDLE       2'h0
`define LSP_DET_OPEN       2'h1
`define LSP_DET_SHORT      2'h2
// Reset values
`define LSP_RST_CONFIG     8'h00
`define LSP_RST_GCL        8'h00
`define LSP_RST_PULL       8'h55
`define LSP_RST_LED        8'h00
`define LSP_RST_FAULT      6'h00
// Timing: times in ns, clock period in ns, counts are least times rounded up
`define LSP_CLK_NS         8
`define LSP_T_SCAN_NS      33000
`define LSP_T_BLANK_NS     830
`define LSP_T_CDLY_NS      300
`define LSP_SCAN_CYC       ((`LSP_T_SCAN_NS + `LSP_CLK_NS - 1) / `LSP_CLK_NS)
`define LSP_BLANK_CYC      ((`LSP_T_BLANK_NS + `LSP_CLK_NS - 1) / `LSP_CLK_NS)
`define LSP_CDLY_CYC       ((`LSP_T_CDLY_NS + `LSP_CLK_NS - 1) / `LSP_CLK_NS)
// PWM step prescale: 16 clocks per step, 256 steps fill the slot
`define LSP_PRE_LAST       4'hF
`define LSP_PWM_LAST       8'hFF
// Slot ends counted per detection: one partial slot plus two full scans
`define LSP_DET_SLOTS      5'h10
`define LSP_DET_FIRST_CAP  5'h09
`endif

// ### rtl/lsp_col_sink.v
// One column current sink: registered PWM compare for the active row
`timescale 1ns/100ps
`default_nettype none
module lsp_col_sink (
  input  wire       mclk,        // Core clock
  input  wire       rstn,        // Async reset, active low
  input  wire       slot_on,     // Row slot driving phase
  input  wire [7:0] pwm_cnt,     // Slot PWM counter
  input  wire [7:0] bright,      // Stored brightness of this LED
  input  wire [7:0] scale,       // Scaling value, zero turns LED off
  output reg        sink_q       // Column sink enable
);
  ////////////////////////////////////////////////////////////////////////
  // Sink on while counter below brightness
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sink_q <= 1'b0;
    end else begin
      sink_q <= slot_on && (scale != 8'h00) && (pwm_cnt < bright); // [RULE3] [RULE15]
    end
  end
endmodule // lsp_col_sink
`default_nettype wire

// ### rtl/lsp_top.v
// LED matrix row scan, per-LED PWM and open/short detection capture
`timescale 1ns/100ps
`default_nettype none
`include "lsp_map.vh"
// Function
// [RULE1] Eight rows enabled one at a time, repeating
// [RULE2] Slot 33us, then 0.83us blank, 0.3us delay
// [RULE3] On time in 256 steps of brightness/256
// [RULE4] PWM only; value is plain binary step count
// [RULE5] Brightness rewrites apply to following scans; here they reach the sinks from the next clock, within the current slot
// [RULE6] Host writes gamma table values, 0 to 255
// [RULE7] Host picks 32 or 64 gamma steps
// [RULE8] Trigger 00 to 01 or 10 starts capture
// [RULE9] Results valid after two full scan cycles
// [RULE10] Scaled-off LEDs keep their old fault bits
// [RULE11] Host sets current level 0x0F..0x40 first
// [RULE12] Host writes pull register 0x00 first
// [RULE13] One capture per trigger; rearm through 00
// [RULE14] Six fault bits low, upper two zero
// [RULE15] PWM counter restarts each slot, compare below
module lsp_top #(
  parameter SCAN_CYC = `LSP_SCAN_CYC                 // Row slot length in clocks
) (
  input  wire        mclk,                           // Core clock, 125 MHz
  input  wire        rstn,                           // Async reset, active low
  input  wire        reg_wr,                         // Register write strobe
  input  wire        reg_rd,                         // Register read strobe
  input  wire [1:0]  reg_page,                       // Register page
  input  wire [7:0]  reg_addr,                       // Register offset in page
  input  wire [7:0]  reg_wdata,                      // Write data
  input  wire [17:0] open_sense,                     // Column open comparator results
  input  wire [17:0] short_sense,                    // Column short comparator results
  output reg  [7:0]  reg_rdata_q,                    // Read data, one clock after strobe
  output reg  [7:0]  row_switch_line_q,              // Row switches, active high
  output wire [17:0] column_current_sink,            // Column sinks, from flops
  output reg         detect_busy_q                   // Detection capture in progress
);
  localparam integer SCAN_LAST_I  = SCAN_CYC - 1;            // Last slot clock, full width
  localparam integer BLANK_LAST_I = `LSP_BLANK_CYC - 1;      // Last blank clock, full width
  localparam integer CDLY_LAST_I  = `LSP_CDLY_CYC - 1;       // Last delay clock, full width
  localparam [12:0]  SCAN_LAST    = SCAN_LAST_I[12:0];       // Cut to counter width
  localparam [12:0]  BLANK_LAST   = BLANK_LAST_I[12:0];      // Cut to counter width
  localparam [12:0]  CDLY_LAST    = CDLY_LAST_I[12:0];       // Cut to counter width
  // One-hot scan states
  localparam [2:0] S_SCAN  = 3'h1;
  localparam [2:0] S_BLANK = 3'h2;
  localparam [2:0] S_CDLY  = 3'h4;

  reg [7:0]  bright_mem [0:`LSP_LEDS-1];             // Brightness per LED
  reg [7:0]  scale_mem  [0:`LSP_LEDS-1];             // Scaling per LED
  reg [5:0]  fault_mem  [0:`LSP_FAULT_REGS-1];       // Captured fault bits
  reg [7:0]  config_q;                               // Configuration register
  reg [7:0]  gcl_q;                                  // Global current level
  reg [7:0]  pull_q;                                 // Pull resistor selection
  reg [2:0]  state_q;                                // Scan state
  reg [12:0] cnt_q;                                  // Phase cycle counter
  reg [2:0]  row_q;                                  // Active row index
  reg [3:0]  pre_q;                                  // PWM step prescaler
  reg [7:0]  pwm_q;                                  // PWM compare counter
  reg [1:0]  trig_prev_q;                            // Trigger field last cycle
  reg        armed_q;                                // Trigger returned to idle
  reg [1:0]  det_mode_q;                             // Open or short capture
  reg [4:0]  det_cnt_q;                              // Slot ends seen in capture
  reg [7:0]  rd_d;                                   // Read mux result
  integer    i;                                      // Loop index, register reset
  reg        run_q;                                  // Run bit taken at slot boundary
  integer    j;                                      // Loop index, detection capture

  wire [1:0] trig      = config_q[`LSP_CFG_DET_MSB:`LSP_CFG_DET_LSB];
  wire       run       = config_q[`LSP_CFG_RUN_BIT];
  wire       slot_end  = state_q[0] && (cnt_q == SCAN_LAST);
  wire [7:0] row_base  = {5'h00, row_q} * 8'h12;
  wire       led_addr  = (reg_addr <= `LSP_LED_LAST);
  wire       fault_adr = (reg_addr >= `LSP_OFF_FAULT_LO) && (reg_addr <= `LSP_OFF_FAULT_HI);
  wire [4:0] fault_idx = reg_addr[4:0] - 5'h03;

  ////////////////////////////////////////////////////////////////////////
  // Register writes; arrays reset to blank display
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      config_q <= `LSP_RST_CONFIG;
      gcl_q    <= `LSP_RST_GCL;
      pull_q   <= `LSP_RST_PULL;
      for (i = 0; i < `LSP_LEDS; i = i + 1) begin
        bright_mem[i] <= `LSP_RST_LED;
        scale_mem[i]  <= `LSP_RST_LED;
      end
    end else if (reg_wr) begin
      case (reg_page)
        `LSP_PG_BRIGHT: begin
          if (led_addr) bright_mem[reg_addr] <= reg_wdata; // [RULE4] [RULE5]
        end
        `LSP_PG_SCALE: begin
          if (led_addr) scale_mem[reg_addr] <= reg_wdata;
        end
        `LSP_PG_FUNC: begin
          case (reg_addr)
            `LSP_OFF_CONFIG: config_q <= reg_wdata;
            `LSP_OFF_GCL:    gcl_q    <= reg_wdata;
            `LSP_OFF_PULL:   pull_q   <= reg_wdata;
            default:         config_q <= config_q; // Fault and unmapped: ignored
          endcase
        end
        default: config_q <= config_q;             // Unmapped page ignored
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped reads return zero
  always @* begin
    rd_d = 8'h00;
    case (reg_page)
      `LSP_PG_BRIGHT: if (led_addr) rd_d = bright_mem[reg_addr];
      `LSP_PG_SCALE:  if (led_addr) rd_d = scale_mem[reg_addr];
      `LSP_PG_FUNC: begin
        if (reg_addr == `LSP_OFF_CONFIG)    rd_d = config_q;
        else if (reg_addr == `LSP_OFF_GCL)  rd_d = gcl_q;
        else if (reg_addr == `LSP_OFF_PULL) rd_d = pull_q;
        else if (fault_adr)                 rd_d = {2'b00, fault_mem[fault_idx]}; // [RULE14]
      end
      default: rd_d = 8'h00;
    endcase
  end

  // Read data register
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Row scan sequencer: slot, blank gap, column delay
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q           <= S_SCAN;
      cnt_q             <= 13'h0000;
      row_q             <= 3'h0;
      row_switch_line_q <= 8'h00;
      run_q             <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 13'h0001;
      case (state_q)
        S_SCAN: begin
          // Row stays lit through the last slot clock; blank clears it
          row_switch_line_q <= run_q ? (8'h01 << row_q) : 8'h00; // [RULE1]
          if (cnt_q == SCAN_LAST) begin                          // [RULE2]
            state_q <= S_BLANK;
            cnt_q   <= 13'h0000;
          end
        end
        S_BLANK: begin
          row_switch_line_q <= 8'h00;
          if (cnt_q == BLANK_LAST) begin                         // [RULE2]
            state_q <= S_CDLY;
            cnt_q   <= 13'h0000;
          end
        end
        S_CDLY: begin
          row_switch_line_q <= 8'h00;
          if (cnt_q == CDLY_LAST) begin                          // [RULE2]
            state_q <= S_SCAN;
            cnt_q   <= 13'h0000;
            row_q   <= row_q + 3'h1;                             // [RULE1]
            run_q   <= run;                                      // No partial slots [RULE2]
          end
        end
        default: begin
          state_q <= S_SCAN;
          cnt_q   <= 13'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PWM counter: zero outside slot, one step per 16 clocks, saturates
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 4'h0;
      pwm_q <= 8'h00;
    end else if (!state_q[0] || slot_end) begin
      pre_q <= 4'h0;                                             // [RULE15]
      pwm_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 4'h1;
      if (pre_q == `LSP_PRE_LAST && pwm_q != `LSP_PWM_LAST) begin
        pwm_q <= pwm_q + 8'h01;                                  // [RULE3]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Column sinks, one per column, reading active row's values
  genvar c;
  generate
    for (c = 0; c < `LSP_COLS; c = c + 1) begin : g_col
      localparam [7:0] CI = c;
      wire [7:0] idx = row_base + CI;
      lsp_col_sink u_sink (
        .mclk    (mclk),
        .rstn    (rstn),
        .slot_on (state_q[0] && run_q),
        .pwm_cnt (pwm_q),
        .bright  (bright_mem[idx]),
        .scale   (scale_mem[idx]),
        .sink_q  (column_current_sink[c])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Detection trigger, one capture per arming, fault bits taken in the second of two full scans
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trig_prev_q   <= `LSP_DET_IDLE;
      armed_q       <= 1'b1;
      det_mode_q    <= `LSP_DET_IDLE;
      det_cnt_q     <= 5'h00;
      detect_busy_q <= 1'b0;
      for (j = 0; j < `LSP_FAULT_REGS; j = j + 1) begin
        fault_mem[j] <= `LSP_RST_FAULT;
      end
    end else begin
      trig_prev_q <= trig;
      if (trig == `LSP_DET_IDLE) begin
        armed_q <= 1'b1;                                         // [RULE13]
      end
      if (armed_q && trig_prev_q == `LSP_DET_IDLE &&
          (trig == `LSP_DET_OPEN || trig == `LSP_DET_SHORT)) begin
        armed_q       <= 1'b0;                                   // [RULE13]
        det_mode_q    <= trig;                                   // [RULE8]
        det_cnt_q     <= 5'h00;
        detect_busy_q <= 1'b1;
      end else if (detect_busy_q && slot_end) begin
        det_cnt_q <= det_cnt_q + 5'h01;
        if (det_cnt_q >= `LSP_DET_FIRST_CAP) begin
          for (j = 0; j < `LSP_COLS; j = j + 1) begin
            if (scale_mem[row_base + j[7:0]] != 8'h00) begin     // [RULE10]
              fault_mem[row_q * 3 + j / 6][j % 6] <=
                (det_mode_q == `LSP_DET_OPEN) ? open_sense[j] : short_sense[j];
            end
          end
        end
        if (det_cnt_q == `LSP_DET_SLOTS) begin
          detect_busy_q <= 1'b0;                                 // [RULE9]
        end
      end
    end
  end
endmodule // lsp_top
`default_nettype wire

// ### verification/lsp_chk_properties.sv
// Port checker for the scan PWM block
`timescale 1ns/100ps
`default_nettype none
module lsp_chk #(
  parameter SCAN_CYC = 4125                    // Row slot clocks
) (
  input wire logic        mclk,                // Core clock
  input wire logic        rstn,                // Reset, active low
  input wire logic        reg_wr,              // Write strobe
  input wire logic        reg_rd,              // Read strobe
  input wire logic [1:0]  reg_page,            // Page
  input wire logic [7:0]  reg_addr,            // Offset
  input wire logic [7:0]  reg_rdata_q,         // Read data
  input wire logic [7:0]  row_switch_line_q,   // Row lines
  input wire logic [17:0] column_current_sink, // Column sinks
  input wire logic        detect_busy_q        // Capture running
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire  [7:0]  row = row_switch_line_q;        // Short alias
  logic [7:0]  last_q;                         // Last lit row
  logic [15:0] on_q;                           // Lit cycles
  logic [19:0] busy_q;                         // Busy cycles
  ////////////////////////////////////////
  // Row history and run lengths
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 8'h00;
      on_q <= 16'h0000;
      busy_q <= 20'h00000;
    end else begin
      if (|row) last_q <= row;
      on_q <= (|row) ? on_q + 16'h0001 : 16'h0000;
      busy_q <= detect_busy_q ? busy_q + 20'h00001 : 20'h00000;
    end
  end
  a_row_onehot: assert property (
    $onehot0(row)) else $error("two rows lit");
  a_row_order: assert property (
    $rose(|row) && last_q != 8'h00 |-> row == {last_q[6:0], last_q[7]}) else $error("row order");
  a_slot_len: assert property (
    $fell(|row) |-> on_q == SCAN_CYC) else $error("slot length");
  a_gap_len: assert property (
    $fell(|row) |-> ##141 row == 8'h00 ##1 row != 8'h00) else $error("gap length");
  a_sink_slot: assert property (
    $rose(|column_current_sink) |-> |row) else $error("sink outside slot");
  a_busy_len: assert property (
    $fell(detect_busy_q) |-> busy_q >= 16 * SCAN_CYC) else $error("capture too short");
  a_busy_cause: assert property (
    $rose(detect_busy_q) |-> $past(reg_wr, 2) && $past(reg_page, 2) == 2'h2
      && $past(reg_addr, 2) == 8'h00) else $error("capture without trigger");
  a_fault_upper: assert property (
    reg_rd && reg_page == 2'h2 && reg_addr >= 8'h03 && reg_addr <= 8'h1A
      |=> reg_rdata_q[7:6] == 2'h0) else $error("fault upper bits");
endmodule // lsp_chk
bind lsp_top lsp_chk #(.SCAN_CYC(SCAN_CYC)) chk_u (.mclk(mclk), .rstn(rstn),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr),
  .reg_rdata_q(reg_rdata_q), .row_switch_line_q(row_switch_line_q),
  .column_current_sink(column_current_sink), .detect_busy_q(detect_busy_q));
`default_nettype wire

// ### verification/lsp_matrix_model.sv
// LED matrix model with a few faulty LEDs
`timescale 1ns/100ps
`default_nettype none
module lsp_matrix_model (
  input  wire logic [7:0]  row,          // Row switch lines
  output wire logic [17:0] open_sense,   // Open comparators
  output wire logic [17:0] short_sense   // Short comparators
);
  // Open at row 2 col 0 and row 7 col 17, short at row 0 col 5
  // Unlit matrix floats, comparators then read all high
  assign open_sense = ~|row ? 18'h3FFFF : {row[7], 16'h0000, row[2]};
  assign short_sense = ~|row ? 18'h3FFFF : {12'h000, row[0], 5'h00};
endmodule // lsp_matrix_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the scan PWM block
`timescale 1ns/100ps
`default_nettype none
`include "lsp_map.vh"
module tb_top;
  localparam SC = 300;                                    // Short slot
  localparam SLOT = SC + `LSP_BLANK_CYC + `LSP_CDLY_CYC;  // Row period
  localparam logic [1:0] PB = `LSP_PG_BRIGHT;             // Pages
  localparam logic [1:0] PS = `LSP_PG_SCALE;
  localparam logic [1:0] PF = `LSP_PG_FUNC;
  logic        mclk, rstn, reg_wr, reg_rd;                // Bus inputs
  logic [1:0]  reg_page;
  logic [7:0]  reg_addr, reg_wdata;
  wire  [17:0] open_sense, short_sense, sink;             // Matrix side
  wire  [7:0]  rdata, row;
  wire         busy;
  int          err_total, num_checks;                     // Tallies
  logic [7:0]  led[6] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h24, 8'h8F};
  lsp_top #(.SCAN_CYC(SC)) dut_u (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .open_sense(open_sense), .short_sense(short_sense), .reg_rdata_q(rdata),
    .row_switch_line_q(row), .column_current_sink(sink), .detect_busy_q(busy));
  lsp_matrix_model mdl_u (.row(row), .open_sense(open_sense), .short_sense(short_sense));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One-cycle strobes launched at the falling edge
  task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_page = p;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] p, input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_page = p;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    check(18'(rdata), 18'(e));
  endtask
  // Bounded wait on busy (s=0) or row 0 (s=1)
  task automatic hold(input bit s, input logic v);
    int n = 0;
    while ((s ? row[0] : busy) !== v && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20000) begin
      err_total++;
      print_verdict;
    end
  endtask
  // Sink on-cycles of columns 0..2 over one row 0 period
  task automatic measure(input int e0, input int e1, input int e2);
    int cnt[3] = '{0, 0, 0};
    int ex[3] = '{e0, e1, e2};
    hold(1'b1, 1'b0);
    hold(1'b1, 1'b1);
    repeat (SLOT) begin
      for (int c = 0; c < 3; c++) cnt[c] += int'(sink[c]);
      @(negedge mclk);
    end
    for (int c = 0; c < 3; c++) check(18'(cnt[c]), 18'(ex[c]));
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_page = 2'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    err_total = 0;
    num_checks = 0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    rd(PF, 8'h00, 8'h00);
    rd(PF, 8'h02, 8'h55);
    rd(PB, 8'h8F, 8'h00);
    rd(PS, 8'h00, 8'h00);
    rd(PF, 8'h1A, 8'h00);
    wr(PF, 8'h01, 8'h20);
    wr(PF, 8'h02, 8'h00);
    wr(PF, 8'h03, 8'hFF);
    wr(2'h3, 8'h00, 8'hFF);
    wr(PB, 8'h8F, 8'hFF);
    rd(PF, 8'h01, 8'h20);
    rd(PF, 8'h02, 8'h00);
    rd(PF, 8'h03, 8'h00);
    rd(2'h3, 8'h00, 8'h00);
    rd(PB, 8'h90, 8'h00);
    rd(PB, 8'h8F, 8'hFF);
    foreach (led[i]) wr(PS, led[i], 8'h80);
    wr(PB, 8'h01, 8'h04);
    wr(PB, 8'h02, 8'h11);
    wr(PF, 8'h00, 8'h01);
    measure(0, 64, 272);
    wr(PB, 8'h01, 8'h02);
    measure(0, 32, 272);
    wr(PF, 8'h00, 8'h03);
    hold(1'b0, 1'b1);
    hold(1'b0, 1'b0);
    rd(PF, 8'h09, 8'h01);
    rd(PF, 8'h1A, 8'h20);
    rd(PF, 8'h03, 8'h00);
    wr(PF, 8'h00, 8'h03);
    repeat (4) @(negedge mclk);
    check(18'(busy), 18'h00000);
    wr(PS, 8'h8F, 8'h00);
    wr(PF, 8'h00, 8'h01);
    wr(PF, 8'h00, 8'h05);
    hold(1'b0, 1'b1);
    hold(1'b0, 1'b0);
    rd(PF, 8'h03, 8'h20);
    rd(PF, 8'h09, 8'h00);
    rd(PF, 8'h1A, 8'h20);
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
